//--- hw/ubt_pkg.sv
package ubt_pkg;
  localparam int unsigned ubt_data_bits = 8;
  localparam int unsigned ubt_frame_bits = 11;
  localparam int unsigned ubt_shift_bits = 10;
  localparam int unsigned ubt_gap_clocks = 2;
  localparam logic [7:0] ubt_divisor_reset = 8'hff;
  localparam logic [7:0] ubt_divisor_min = 8'h08;
  typedef enum logic [1:0] {ubt_tx_idle = 2'b00, ubt_tx_shift = 2'b01, ubt_tx_gap = 2'b11} ubt_tx_e;
  typedef enum logic [1:0] {ubt_rx_idle = 2'b00, ubt_rx_shift = 2'b01, ubt_rx_stop = 2'b11} ubt_rx_e;
endpackage

//--- hw/ubt_uart.sv
module ubt_uart
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // base clock enable and configuration
  input wire logic i_base_clk_en,
  input wire logic i_channel_enable_bit,
  input wire logic i_receive_enable_bit,
  input wire logic i_transmit_enable_bit,
  input wire logic [7:0] i_divisor_value_field,
  // transmit holding register write
  input wire logic i_tx_write,
  input wire logic [ubt_pkg::ubt_data_bits-1:0] i_tx_data,
  // serial pins
  input wire logic i_serial_rx_pin,
  output logic o_serial_tx_pin,
  // status
  output logic o_tx_holding_full_flag,
  output logic o_tx_shifter_busy_flag,
  output logic o_rx_valid,
  output logic [ubt_pkg::ubt_data_bits-1:0] o_rx_data,
  output logic o_rx_frame_error
);
  import ubt_pkg::*;

  logic tick;
  logic run;
  assign run = i_channel_enable_bit;
  assign tick = run & i_base_clk_en;

  // transmit state
  ubt_tx_e tx_st_q, tx_st_d;
  logic [7:0] tx_cnt_q, tx_cnt_d;
  logic tx_half_q, tx_half_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic [7:0] hold_q, hold_d;
  logic full_q, full_d;
  logic pin_q, pin_d;
  logic [1:0] gap_q, gap_d;
  logic busy_q, busy_d;

  always_comb
  begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_half_d = tx_half_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    hold_d = hold_q;
    full_d = full_q;
    pin_d = pin_q;
    gap_d = gap_q;
    if (!run || !i_transmit_enable_bit)
    begin
      tx_st_d = ubt_tx_idle;
      full_d = 1'b0;
      pin_d = 1'b1;
    end
    else
    begin
      if (i_tx_write && !full_q)
      begin
        hold_d = i_tx_data;
        full_d = 1'b1;
      end
      if (tick)
      begin
        unique case (tx_st_q)
          ubt_tx_idle:
          begin
            if (full_q)
            begin
              tx_sh_d = {1'b1, hold_q, 1'b0};
              full_d = 1'b0;
              pin_d = 1'b0;
              tx_cnt_d = 8'h01;
              tx_half_d = 1'b0;
              tx_bit_d = 4'h0;
              tx_st_d = ubt_tx_shift;
            end
          end
          ubt_tx_shift:
          begin
            if (tx_cnt_q == i_divisor_value_field)
            begin
              tx_cnt_d = 8'h01;
              tx_half_d = ~tx_half_q;
              if (tx_half_q)
              begin
                if (tx_bit_q == 4'(ubt_shift_bits - 1))
                begin
                  gap_d = 2'h1; // idle load tick is the second gap clock
                  tx_st_d = ubt_tx_gap;
                end
                else
                begin
                  tx_bit_d = tx_bit_q + 4'h1;
                  pin_d = tx_sh_q[tx_bit_q + 4'h1];
                end
              end
            end
            else
            begin
              tx_cnt_d = tx_cnt_q + 8'h01;
            end
          end
          ubt_tx_gap:
          begin
            gap_d = gap_q + 2'h1;
            if (gap_q == 2'(ubt_gap_clocks - 1))
            begin
              tx_st_d = ubt_tx_idle;
            end
          end
          default:
          begin
            tx_st_d = ubt_tx_idle;
          end
        endcase
      end
    end
    busy_d = (tx_st_d != ubt_tx_idle);
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      busy_q <= 1'b0;
      tx_st_q <= ubt_tx_idle;
      tx_cnt_q <= 8'h01;
      tx_half_q <= 1'b0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3ff;
      hold_q <= 8'h00;
      full_q <= 1'b0;
      pin_q <= 1'b1;
      gap_q <= 2'h0;
    end
    else
    begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_half_q <= tx_half_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      hold_q <= hold_d;
      full_q <= full_d;
      pin_q <= pin_d;
      gap_q <= gap_d;
      busy_q <= busy_d;
    end
  end

  assign o_serial_tx_pin = pin_q;
  assign o_tx_holding_full_flag = full_q;
  assign o_tx_shifter_busy_flag = busy_q;

  // receive state
  ubt_rx_e rx_st_q, rx_st_d;
  logic [7:0] rx_cnt_q, rx_cnt_d;
  logic rx_half_q, rx_half_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic [7:0] rx_dat_q, rx_dat_d;
  logic rx_vld_q, rx_vld_d;
  logic rx_fe_q, rx_fe_d;

  always_comb
  begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_half_d = rx_half_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_dat_d = rx_dat_q;
    rx_vld_d = 1'b0;
    rx_fe_d = rx_fe_q;
    if (!run || !i_receive_enable_bit)
    begin
      rx_st_d = ubt_rx_idle;
      rx_fe_d = 1'b0;
    end
    else if (tick)
    begin
      unique case (rx_st_q)
        ubt_rx_idle:
        begin
          if (!i_serial_rx_pin)
          begin
            rx_cnt_d = 8'h01;
            rx_half_d = 1'b0;
            rx_bit_d = 4'h0;
            rx_st_d = ubt_rx_shift;
          end
        end
        ubt_rx_shift, ubt_rx_stop:
        begin
          if (rx_cnt_q == i_divisor_value_field)
          begin
            rx_cnt_d = 8'h01;
            rx_half_d = ~rx_half_q;
            if (!rx_half_q && rx_bit_q == 4'h0 && i_serial_rx_pin)
            begin
              rx_st_d = ubt_rx_idle;
            end
            else if (!rx_half_q && rx_st_q == ubt_rx_stop)
            begin
              rx_dat_d = rx_sh_q;
              rx_vld_d = 1'b1;
              rx_fe_d = ~i_serial_rx_pin;
              rx_st_d = ubt_rx_idle;
            end
            else if (!rx_half_q && rx_bit_q != 4'h0)
            begin
              rx_sh_d = {i_serial_rx_pin, rx_sh_q[7:1]};
            end
            else if (rx_half_q)
            begin
              rx_bit_d = rx_bit_q + 4'h1;
              if (rx_bit_q == 4'(ubt_data_bits))
              begin
                rx_st_d = ubt_rx_stop;
              end
            end
          end
          else
          begin
            rx_cnt_d = rx_cnt_q + 8'h01;
          end
        end
        default:
        begin
          rx_st_d = ubt_rx_idle;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_st_q <= ubt_rx_idle;
      rx_cnt_q <= 8'h01;
      rx_half_q <= 1'b0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_dat_q <= 8'h00;
      rx_vld_q <= 1'b0;
      rx_fe_q <= 1'b0;
    end
    else
    begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_half_q <= rx_half_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_dat_q <= rx_dat_d;
      rx_vld_q <= rx_vld_d;
      rx_fe_q <= rx_fe_d;
    end
  end

  assign o_rx_valid = rx_vld_q;
  assign o_rx_data = rx_dat_q;
  assign o_rx_frame_error = rx_fe_q;

  // checks
  a_hold_when_stopped: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (run && i_transmit_enable_bit && !i_base_clk_en) |=> $stable(o_serial_tx_pin))
    else $error("tx pin moved without base clock");
  a_gap_after_stop: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (tx_st_q == ubt_tx_shift && tx_st_d == ubt_tx_gap) |=> o_serial_tx_pin && tx_st_q == ubt_tx_gap)
    else $error("no gap after stop bit");
  a_gap_length: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (tx_st_q == ubt_tx_gap && tick && gap_q == 2'h1) |=> tx_st_q != ubt_tx_gap || !run)
    else $error("gap not two base clocks");
  a_start_low: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (tx_st_q == ubt_tx_idle && tx_st_d == ubt_tx_shift) |=> !o_serial_tx_pin && o_tx_shifter_busy_flag)
    else $error("start bit not driven");
  a_flag_step: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (tick && i_transmit_enable_bit && tx_st_q == ubt_tx_idle && full_q && !i_tx_write)
    |=> !o_tx_holding_full_flag && o_tx_shifter_busy_flag)
    else $error("flags did not move to 01");
  a_rx_restart: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (tick && i_receive_enable_bit && rx_st_q == ubt_rx_idle && !i_serial_rx_pin)
    |=> rx_cnt_q == 8'h01 && rx_st_q == ubt_rx_shift)
    else $error("rx timing not restarted");
  a_rx_counter: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (rx_st_q != ubt_rx_idle) |-> rx_cnt_q <= i_divisor_value_field || i_divisor_value_field < ubt_divisor_min)
    else $error("rx counter past divisor");
  a_bit_rate: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (tick && tx_st_q == ubt_tx_shift && tx_cnt_q != i_divisor_value_field) |=> tx_bit_q == $past(tx_bit_q))
    else $error("bit advanced early");
endmodule

//--- test/ubt_remote.sv
module ubt_remote
(
  // fuclk and line from the channel
  input wire logic i_clock,
  input wire logic i_tick,
  input wire logic i_tx,
  input wire logic [7:0] i_k,
  // line into the channel
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  logic [7:0] b;
  int t = 0;
  int last = 0;
  int gap = 0;
  initial o_line = 1'b1;
  // waits n base ticks, so a frozen fuclk freezes the count too
  task automatic tk(input int n);
    repeat (n)
    begin
      @(negedge i_clock);
      while (i_tick !== 1'b1) @(negedge i_clock);
      t++;
    end
  endtask
  // receiver: start-to-start spacing kept in gap
  initial
  begin
    forever
    begin
      tk(1);
      if (i_tx === 1'b0)
      begin
        gap = t - last;
        last = t;
        tk(int'(i_k));
        for (int i = 0; i < 8; i++)
        begin
          tk(2 * int'(i_k));
          b[i] = i_tx;
        end
        tk(2 * int'(i_k));
        q.push_back(b);
      end
    end
  end
  // short low pulse that the receiver must reject as a false start
  task automatic blip(input real w);
    o_line = 1'b0;
    #(w);
    o_line = 1'b1;
    #(4.0 * w);
  endtask
  // transmitter at a skewed bit time, with an extra gap after stop
  task automatic send(input logic [7:0] v, input real bt, input real g);
    o_line = 1'b0;
    #(bt);
    for (int i = 0; i < 8; i++)
    begin
      o_line = v[i];
      #(bt);
    end
    o_line = 1'b1;
    #(bt + g);
  endtask
endmodule

//--- test/test_ubt_uart.sv
module test_ubt_uart;
  timeunit 1ns;
  timeprecision 1ps;
  import ubt_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic tick = 1'b1;
  logic en = 1'b0;
  logic [7:0] k = 8'h08;
  logic wr_p = 1'b0;
  logic [7:0] dat = 8'h00;
  logic rxl, txp, full, busy, rv, fe;
  logic [7:0] rd;
  logic [31:0] lf = 32'h4f8f4aba;
  logic [2:0] hold;
  logic [7:0] eq[$];
  logic [7:0] rq[$];
  logic [7:0] gq[$];
  int mismatches = 0;
  int n_tests = 0;
  int kv[3] = '{8, 0, 255};
  real bt;
  always #4 i_clock = ~i_clock;
  ubt_uart u_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_base_clk_en(tick),
    .i_channel_enable_bit(en), .i_receive_enable_bit(en), .i_transmit_enable_bit(en),
    .i_divisor_value_field(k), .i_tx_write(wr_p), .i_tx_data(dat), .i_serial_rx_pin(rxl),
    .o_serial_tx_pin(txp), .o_tx_holding_full_flag(full), .o_tx_shifter_busy_flag(busy),
    .o_rx_valid(rv), .o_rx_data(rd), .o_rx_frame_error(fe));
  ubt_remote u_rem (.i_clock(i_clock), .i_tick(tick), .i_tx(txp), .i_k(k), .o_line(rxl));
  always @(negedge i_clock) if (rv === 1'b1) gq.push_back(rd);
  function automatic logic [7:0] nxt();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", s, exp, got);
    end
  endtask
  // writer polls the holding-full flag only
  task automatic wr(input logic [7:0] v);
    for (int i = 0; i < 20000 && full !== 1'b0; i++) cyc();
    chk("wr_wait", full, 1'b0);
    wr_p = 1'b1;
    dat = v;
    eq.push_back(v);
    cyc();
    wr_p = 1'b0;
  endtask
  task automatic drain(input logic [7:0] e[$], input logic [7:0] g[$], input string s);
    chk({s, "_n"}, g.size(), e.size());
    foreach (e[i]) chk(s, g[i], e[i]);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    cyc(16);
    i_rst_b = 1'b1;
    cyc();
    chk("idle", {txp, full, busy}, 3'b100);
    for (int j = 0; j < 3; j++)
    begin
      k = kv[j] != 0 ? 8'(kv[j]) : 8'h08 + (nxt() & 8'h07);
      en = 1'b0;
      cyc();
      en = 1'b1;
      cyc();
      wr(nxt());
      chk("fb10", {full, busy}, 2'b10);
      for (int i = 0; i < 20 && !(busy === 1'b1 && full === 1'b0); i++) cyc();
      wr(nxt());
      chk("fb11", {full, busy}, 2'b11);
      cyc();
      wr_p = 1'b1;
      dat = 8'h5a;
      cyc();
      wr_p = 1'b0;
      wr(nxt());
      for (int i = 0; i < 20000 && full !== 1'b0; i++) cyc();
      chk("fb01", {full, busy}, 2'b01);
      for (int i = 0; i < 20000 && busy !== 1'b0; i++) cyc();
      chk("busy_end", busy, 1'b0);
      cyc(4);
      chk("gap", u_rem.gap, 2 * ubt_shift_bits * k + ubt_gap_clocks);
      drain(eq, u_rem.q, "tx");
      eq.delete();
      u_rem.q.delete();
      u_rem.blip(4.0 * k);
      for (int i = 0; i < 2; i++)
      begin
        rq.push_back(nxt());
        bt = 16.0 * k * (i == 0 ? 1.03 : 0.97);
        u_rem.send(rq[i], bt, 16.0);
      end
      cyc(4);
      drain(rq, gq, "rx");
      chk("ferr", fe, 1'b0);
      rq.delete();
      gq.delete();
      $display("test %0d done", j);
    end
    k = 8'h08;
    wr(nxt());
    cyc(60);
    tick = 1'b0;
    hold = {txp, full, busy};
    cyc(40);
    chk("freeze", {txp, full, busy}, hold);
    tick = 1'b1;
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) cyc();
    chk("frz_end", busy, 1'b0);
    cyc(4);
    drain(eq, u_rem.q, "frz");
    en = 1'b0;
    cyc();
    chk("reinit", {txp, full, busy}, 3'b100);
    $display("test freeze done");
    wrap_up();
  end
endmodule
